// file: mpg_pkg.sv
// Contract
// - Disabled: edge writes load active register immediately
// - Enabled: edge writes wait in shadow buffer
// - Rise value moves on fall, fall on rise
// - Passed edge value waits for next count cycle
// - Port bits gate enabled outputs, generators keep running
// - Gate select 01 AND, 10 OR, else pass-through
// - OR with 1 forces high, AND with 0 low
// - Common dead band before complementary rising edge
// - Dead band equals field value in clocks
// - Enabled trip input event forces trip state
// - Trip sets detected flag; zero means none
// - Only software clear releases trip state
// - True and inverted groups tripped together, each with its own level
// - Float select zero tristates; level 0 high
// - Trip source enables bits 7:4, flag bit 0
// - Complement bit drives inverted outputs of enabled pairs
// - Generator, multi and broadcast enable bit layout
`default_nettype none
package mpg_pkg;
	localparam int         NUM_GEN       = 4;
	localparam int         CLK_HZ        = 20_000_000;
	localparam int         ADDR_LSB      = 2;
	localparam int         ADDR_MSB      = 9;
	localparam logic [7:0] IDX_ENABLE    = 8'h79;
	localparam logic [7:0] IDX_GATING    = 8'h7a;
	localparam logic [7:0] IDX_TRIP      = 8'h7b;
	localparam logic [7:0] IDX_RISE_BASE = 8'h60;
	localparam logic [7:0] IDX_FALL_BASE = 8'h68;
	localparam logic [7:0] REG_RESET     = 8'h00;
	localparam logic [15:0] EDGE_RESET   = 16'h0000;
	localparam int         EN_MULTI      = 0;
	localparam int         EN_GEN_LSB    = 1;
	localparam int         EN_BCAST      = 5;
	localparam int         EN_TRIP       = 6;
	localparam int         EN_CMPL       = 7;
	localparam int         GD_DLY_LSB    = 0;
	localparam int         GD_TRUE_LSB   = 4;
	localparam int         GD_INV_LSB    = 6;
	localparam int         TP_FLAG       = 0;
	localparam int         TP_INV_LVL    = 1;
	localparam int         TP_TRUE_LVL   = 2;
	localparam int         TP_FLOAT      = 3;
	localparam int         TP_SRC_LSB    = 4;
	localparam logic [1:0] GATE_AND      = 2'h1;
	localparam logic [1:0] GATE_OR       = 2'h2;
	localparam logic [3:0] DLY_ZERO      = 4'h0;
	localparam logic [3:0] DLY_ONE       = 4'h1;
endpackage
`default_nettype wire

// file: mpg_top.sv
`default_nettype none
module mpg_top (
	input  wire logic        clk,          // System clock.
	input  wire logic        rst,          // Asynchronous reset, active high.
	input  wire logic        hsel,         // Slave select.
	input  wire logic [31:0] haddr,        // Byte address.
	input  wire logic [1:0]  htrans,       // Transfer type.
	input  wire logic        hwrite,       // Write when high.
	input  wire logic [2:0]  hsize,        // Transfer size, word only.
	input  wire logic [31:0] hwdata,       // Write data.
	input  wire logic        hready,       // Bus ready in.
	output logic             hreadyout,    // Always ready.
	output logic             hresp,        // Always OKAY.
	output logic [31:0]      hrdata,       // Read data.
	input  wire logic [15:0] timer_count,  // Down counter value.
	input  wire logic        count_tick,   // Counter took a new value.
	input  wire logic [7:0]  port_out,     // Port output register bits.
	input  wire logic [3:0]  trip_in,      // Trip inputs 0 to 3.
	output logic [3:0]       pwm_true,     // True outputs.
	output logic [3:0]       pwm_true_oe,  // True output enables.
	output logic [3:0]       pwm_inv,      // Inverted outputs.
	output logic [3:0]       pwm_inv_oe    // Inverted output enables.
);
	localparam int N = mpg_pkg::NUM_GEN;

	logic [7:0]  enable_control_reg;
	logic [7:0]  gating_deadband_reg;
	logic [7:0]  trip_config_reg;
	logic [15:0] rise_act [N];
	logic [15:0] fall_act [N];
	logic [15:0] rise_buf [N];
	logic [15:0] fall_buf [N];
	logic [N-1:0] rise_pend;
	logic [N-1:0] fall_pend;
	logic [N-1:0] gen_lvl;
	logic [N-1:0] db_lvl;
	logic [3:0]  db_cnt [N];
	logic [3:0]  trip_s1;
	logic [3:0]  trip_s2;
	logic [3:0]  trip_s3;
	logic        wr_pend;
	logic [7:0]  wr_idx;
	logic [31:0] rdata;
	logic [3:0]  out_t;
	logic [3:0]  out_t_oe;
	logic [3:0]  out_i;
	logic [3:0]  out_i_oe;

	logic [7:0]  next_enable_control_reg;
	logic [7:0]  next_gating_deadband_reg;
	logic [7:0]  next_trip_config_reg;
	logic [15:0] next_rise_act [N];
	logic [15:0] next_fall_act [N];
	logic [15:0] next_rise_buf [N];
	logic [15:0] next_fall_buf [N];
	logic [N-1:0] next_rise_pend;
	logic [N-1:0] next_fall_pend;
	logic [N-1:0] next_gen_lvl;
	logic [N-1:0] next_db_lvl;
	logic [3:0]  next_db_cnt [N];
	logic [3:0]  next_trip_s1;
	logic [3:0]  next_trip_s2;
	logic [3:0]  next_trip_s3;
	logic        next_wr_pend;
	logic [7:0]  next_wr_idx;
	logic [31:0] next_rdata;
	logic [3:0]  next_out_t;
	logic [3:0]  next_out_t_oe;
	logic [3:0]  next_out_i;
	logic [3:0]  next_out_i_oe;

	// True when idx is the word index of one edge register of generator k.
	function automatic logic edge_hit(input logic [7:0] idx, input logic [7:0] base,
		input int k);
		edge_hit = (idx == 8'(base + 8'(k)));
	endfunction

	// Combines one output with its port bit as the select code asks.
	function automatic logic gate(input logic [1:0] sel, input logic pwm, input logic pbit);
		case (sel)
			mpg_pkg::GATE_AND: gate = pwm & pbit;
			mpg_pkg::GATE_OR:  gate = pwm | pbit;
			default:           gate = pwm;
		endcase
	endfunction

	// The slave never stalls, so both handshake outputs are constants.
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata;
	assign pwm_true    = out_t;
	assign pwm_true_oe = out_t_oe;
	assign pwm_inv     = out_i;
	assign pwm_inv_oe  = out_i_oe;

	// Next state of bus, registers, generators, dead band and pins.
	always_comb begin
		logic       acc;
		logic       trip_ev;
		logic       multi;
		logic       bcast;
		logic       running;
		logic       raw;
		logic       settled;
		logic       db_t;
		logic       db_i;
		logic       en;
		logic       tripped;
		logic [3:0] dly;
		acc = 1'b0;
		trip_ev = 1'b0;
		multi = 1'b0;
		bcast = 1'b0;
		running = 1'b0;
		raw = 1'b0;
		settled = 1'b0;
		db_t = 1'b0;
		db_i = 1'b0;
		en = 1'b0;
		tripped = 1'b0;
		dly = mpg_pkg::DLY_ZERO;
		next_enable_control_reg  = enable_control_reg;
		next_gating_deadband_reg = gating_deadband_reg;
		next_trip_config_reg     = trip_config_reg;
		next_rise_act  = rise_act;
		next_fall_act  = fall_act;
		next_rise_buf  = rise_buf;
		next_fall_buf  = fall_buf;
		next_rise_pend = rise_pend;
		next_fall_pend = fall_pend;
		next_gen_lvl   = gen_lvl;
		next_db_lvl    = db_lvl;
		next_db_cnt    = db_cnt;
		next_rdata     = rdata;

		// Address phase is captured; the write lands in the data phase.
		acc = hsel & hready & htrans[1];
		next_wr_pend = acc & hwrite;
		next_wr_idx  = acc ? haddr[mpg_pkg::ADDR_MSB:mpg_pkg::ADDR_LSB] : wr_idx;

		// Only the second stage is edge-detected; the first feeds nothing else.
		next_trip_s1 = trip_in;
		next_trip_s2 = trip_s1;
		next_trip_s3 = trip_s2;
		trip_ev = enable_control_reg[mpg_pkg::EN_TRIP] &
			(|(trip_s2 & ~trip_s3 & trip_config_reg[mpg_pkg::TP_SRC_LSB +: 4]));

		if (wr_pend && wr_idx == mpg_pkg::IDX_ENABLE) begin
			next_enable_control_reg = hwdata[7:0];
		end
		if (wr_pend && wr_idx == mpg_pkg::IDX_GATING) begin
			next_gating_deadband_reg = hwdata[7:0];
		end
		// The flag bit is writable only towards zero, and a trip in the same cycle wins.
		if (wr_pend && wr_idx == mpg_pkg::IDX_TRIP) begin
			next_trip_config_reg[7:1] = hwdata[7:1];
			if (!hwdata[mpg_pkg::TP_FLAG]) begin
				next_trip_config_reg[mpg_pkg::TP_FLAG] = 1'b0;
			end
		end
		if (trip_ev) begin
			next_trip_config_reg[mpg_pkg::TP_FLAG] = 1'b1;
		end

		multi = enable_control_reg[mpg_pkg::EN_MULTI];
		bcast = enable_control_reg[mpg_pkg::EN_BCAST];
		dly   = gating_deadband_reg[mpg_pkg::GD_DLY_LSB +: 4];
		tripped = next_trip_config_reg[mpg_pkg::TP_FLAG];

		for (int k = 0; k < N; k++) begin
			running = multi & enable_control_reg[mpg_pkg::EN_GEN_LSB + k];
			// Edges fire only on an exact match, so a value already passed waits a cycle.
			if (!running) begin
				next_gen_lvl[k] = 1'b0;
			end else if (count_tick && !gen_lvl[k] && timer_count == rise_act[k]) begin
				next_gen_lvl[k] = 1'b1;
				if (fall_pend[k]) begin
					next_fall_act[k]  = fall_buf[k];
					next_fall_pend[k] = 1'b0;
				end
			end else if (count_tick && gen_lvl[k] && timer_count == fall_act[k]) begin
				next_gen_lvl[k] = 1'b0;
				if (rise_pend[k]) begin
					next_rise_act[k]  = rise_buf[k];
					next_rise_pend[k] = 1'b0;
				end
			end
			// A stopped generator flushes anything still waiting in its buffer.
			if (!running && rise_pend[k]) begin
				next_rise_act[k]  = rise_buf[k];
				next_rise_pend[k] = 1'b0;
			end
			if (!running && fall_pend[k]) begin
				next_fall_act[k]  = fall_buf[k];
				next_fall_pend[k] = 1'b0;
			end
			if (wr_pend && edge_hit(wr_idx, mpg_pkg::IDX_RISE_BASE, k)) begin
				if (running) begin
					next_rise_buf[k]  = hwdata[15:0];
					next_rise_pend[k] = 1'b1;
				end else begin
					next_rise_act[k]  = hwdata[15:0];
					next_rise_pend[k] = 1'b0;
				end
			end
			if (wr_pend && edge_hit(wr_idx, mpg_pkg::IDX_FALL_BASE, k)) begin
				if (running) begin
					next_fall_buf[k]  = hwdata[15:0];
					next_fall_pend[k] = 1'b1;
				end else begin
					next_fall_act[k]  = hwdata[15:0];
					next_fall_pend[k] = 1'b0;
				end
			end

			// Any change of the source restarts the counter and holds both sides low.
			raw = bcast ? gen_lvl[0] : gen_lvl[k];
			if (raw != db_lvl[k]) begin
				next_db_lvl[k] = raw;
				next_db_cnt[k] = dly;
			end else if (db_cnt[k] != mpg_pkg::DLY_ZERO) begin
				next_db_cnt[k] = db_cnt[k] - mpg_pkg::DLY_ONE;
			end
			settled = (db_cnt[k] == mpg_pkg::DLY_ZERO);
			db_t = db_lvl[k] & settled;
			db_i = ~db_lvl[k] & settled;

			// Gating and trip act on the delayed signals, so they reach the pins at once.
			en = running;
			next_out_t[k] = gate(gating_deadband_reg[mpg_pkg::GD_TRUE_LSB +: 2], db_t,
				port_out[k]);
			next_out_i[k] = gate(gating_deadband_reg[mpg_pkg::GD_INV_LSB +: 2], db_i,
				port_out[k + N]);
			next_out_t_oe[k] = en;
			next_out_i_oe[k] = en & enable_control_reg[mpg_pkg::EN_CMPL];
			if (tripped && en) begin
				if (!trip_config_reg[mpg_pkg::TP_FLOAT]) begin
					next_out_t[k] = 1'b0;
					next_out_i[k] = 1'b0;
					next_out_t_oe[k] = 1'b0;
					next_out_i_oe[k] = 1'b0;
				end else begin
					next_out_t[k] = ~trip_config_reg[mpg_pkg::TP_TRUE_LVL];
					next_out_i[k] = ~trip_config_reg[mpg_pkg::TP_INV_LVL];
				end
			end
		end

		// Reads see the values as they stand after this edge, so a write just before is seen.
		if (acc && !hwrite) begin
			next_rdata = 32'h0000_0000;
			case (haddr[mpg_pkg::ADDR_MSB:mpg_pkg::ADDR_LSB])
				mpg_pkg::IDX_ENABLE: next_rdata[7:0] = next_enable_control_reg;
				mpg_pkg::IDX_GATING: next_rdata[7:0] = next_gating_deadband_reg;
				mpg_pkg::IDX_TRIP:   next_rdata[7:0] = next_trip_config_reg;
				default: begin
					for (int k = 0; k < N; k++) begin
						if (edge_hit(haddr[mpg_pkg::ADDR_MSB:mpg_pkg::ADDR_LSB],
							mpg_pkg::IDX_RISE_BASE, k)) begin
							next_rdata[15:0] = next_rise_pend[k] ? next_rise_buf[k] : next_rise_act[k];
						end
						if (edge_hit(haddr[mpg_pkg::ADDR_MSB:mpg_pkg::ADDR_LSB],
							mpg_pkg::IDX_FALL_BASE, k)) begin
							next_rdata[15:0] = next_fall_pend[k] ? next_fall_buf[k] : next_fall_act[k];
						end
					end
				end
			endcase
		end
	end

	// State registers; all clear to zero on reset.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enable_control_reg  <= mpg_pkg::REG_RESET;
			gating_deadband_reg <= mpg_pkg::REG_RESET;
			trip_config_reg     <= mpg_pkg::REG_RESET;
			for (int k = 0; k < N; k++) begin
				rise_act[k] <= mpg_pkg::EDGE_RESET;
				fall_act[k] <= mpg_pkg::EDGE_RESET;
				rise_buf[k] <= mpg_pkg::EDGE_RESET;
				fall_buf[k] <= mpg_pkg::EDGE_RESET;
				db_cnt[k]   <= mpg_pkg::DLY_ZERO;
			end
			rise_pend <= '0;
			fall_pend <= '0;
			gen_lvl   <= '0;
			db_lvl    <= '0;
			trip_s1   <= '0;
			trip_s2   <= '0;
			trip_s3   <= '0;
			wr_pend   <= 1'b0;
			wr_idx    <= mpg_pkg::REG_RESET;
			rdata     <= 32'h0000_0000;
			out_t     <= '0;
			out_t_oe  <= '0;
			out_i     <= '0;
			out_i_oe  <= '0;
		end else begin
			enable_control_reg  <= next_enable_control_reg;
			gating_deadband_reg <= next_gating_deadband_reg;
			trip_config_reg     <= next_trip_config_reg;
			rise_act  <= next_rise_act;
			fall_act  <= next_fall_act;
			rise_buf  <= next_rise_buf;
			fall_buf  <= next_fall_buf;
			db_cnt    <= next_db_cnt;
			rise_pend <= next_rise_pend;
			fall_pend <= next_fall_pend;
			gen_lvl   <= next_gen_lvl;
			db_lvl    <= next_db_lvl;
			trip_s1   <= next_trip_s1;
			trip_s2   <= next_trip_s2;
			trip_s3   <= next_trip_s3;
			wr_pend   <= next_wr_pend;
			wr_idx    <= next_wr_idx;
			rdata     <= next_rdata;
			out_t     <= next_out_t;
			out_t_oe  <= next_out_t_oe;
			out_i     <= next_out_i;
			out_i_oe  <= next_out_i_oe;
		end
	end
endmodule
`default_nettype wire

// file: mpg_checker.sv
`default_nettype none
module mpg_checker (
	input wire logic        clk,         // Clock.
	input wire logic        rst,         // Reset.
	input wire logic        hsel,        // Select.
	input wire logic [31:0] haddr,       // Address.
	input wire logic [1:0]  htrans,      // Transfer type.
	input wire logic        hwrite,      // Write flag.
	input wire logic [31:0] hwdata,      // Write data.
	input wire logic        hready,      // Bus ready.
	input wire logic [7:0]  port_out,    // Port bits.
	input wire logic [3:0]  trip_in,     // Trip inputs.
	input wire logic [3:0]  pwm_true,    // True pins.
	input wire logic [3:0]  pwm_true_oe, // True enables.
	input wire logic [3:0]  pwm_inv,     // Inverted pins.
	input wire logic [3:0]  pwm_inv_oe   // Inverted enables.
);
	logic       wp;
	logic [7:0] wa, en, gd, tp;
	// Shadow of the control registers, rebuilt from bus writes only.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp <= 1'b0;
			wa <= 8'h00;
			en <= 8'h00;
			gd <= 8'h00;
			tp <= 8'h00;
		end else begin
			wp <= hsel && hready && htrans[1] && hwrite;
			wa <= haddr[9:2];
			if (wp && wa == mpg_pkg::IDX_ENABLE) en <= hwdata[7:0];
			if (wp && wa == mpg_pkg::IDX_GATING) gd <= hwdata[7:0];
			if (wp && wa == mpg_pkg::IDX_TRIP) tp <= hwdata[7:0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_INV_OFF: assert property ((!en[7]) [*4] |-> pwm_inv_oe == 4'h0)
		else $error("inverted pin driven without pair enable");
	AST_GEN0: assert property ((en[4:0] == 5'h03 && !en[6]) [*4] |-> pwm_true_oe == 4'h1)
		else $error("true enables do not follow generator bits");
	AST_MULTI_OFF: assert property ((!en[0]) [*4] |-> (pwm_true_oe | pwm_inv_oe) == 4'h0)
		else $error("pin driven with multi mode off");
	AST_OR_T: assert property ((gd[5:4] == 2'h2 && port_out[0] && !en[6] && pwm_true_oe[0]) [*3]
		|-> pwm_true[0])
		else $error("true pin not forced high by or gating");
	AST_AND_T: assert property ((gd[5:4] == 2'h1 && !port_out[0] && !en[6]) [*3] |-> !pwm_true[0])
		else $error("true pin not forced low by and gating");
	AST_OR_N: assert property ((gd[7:6] == 2'h2 && port_out[4] && !en[6] && pwm_inv_oe[0]) [*3]
		|-> pwm_inv[0])
		else $error("inverted pin not forced high by or gating");
	AST_DB_TI: assert property ($fell(pwm_true[0]) && gd == 8'h03 && en == 8'h83
		|-> (!pwm_inv[0]) [*3] ##[1:2] (pwm_inv[0] || gd != 8'h03))
		else $error("dead band before inverted rise is wrong");
	AST_DB_IT: assert property ($fell(pwm_inv[0]) && gd == 8'h03 && en == 8'h83
		|-> (!pwm_true[0]) [*3])
		else $error("dead band before true rise is too short");
	AST_TRIP_LVL: assert property (en[6] && tp[4] && tp[3:1] == 3'h4 && pwm_true_oe[0] &&
		pwm_inv_oe[0] && $rose(trip_in[0]) |-> ##[2:4] (pwm_true[0] && pwm_inv[0]))
		else $error("trip did not drive both groups high");
	AST_TRIP_FLT: assert property (en[6] && tp[5] && !tp[3] && $rose(trip_in[1])
		|-> ##[2:4] (pwm_true_oe | pwm_inv_oe) == 4'h0)
		else $error("trip did not release the pins");
endmodule
bind mpg_top mpg_checker u_chk (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
	.port_out, .trip_in, .pwm_true, .pwm_true_oe, .pwm_inv, .pwm_inv_oe);
`default_nettype wire

// file: mpg_stage.sv
`default_nettype none
module mpg_stage (
	input  wire logic [3:0] pwm_true,    // True pin values.
	input  wire logic [3:0] pwm_true_oe, // True enables.
	input  wire logic [3:0] pwm_inv,     // Inverted pin values.
	input  wire logic [3:0] pwm_inv_oe,  // Inverted enables.
	input  wire logic [3:0] fault,       // Faults to report.
	output logic [3:0]      gate_t,      // Upper gate levels.
	output logic [3:0]      gate_n,      // Lower gate levels.
	output logic [3:0]      trip_in      // Fault lines.
);
	timeunit 1ns;
	timeprecision 1ns;
	// Gate inputs have pull-downs, so a released pin turns the switch off.
	assign gate_t = pwm_true & pwm_true_oe;
	assign gate_n = pwm_inv & pwm_inv_oe;
	// A fault is reported as a high level on its line.
	assign trip_in = fault;
endmodule
`default_nettype wire

// file: mpg_top_tb.sv
`default_nettype none
module mpg_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        count_tick = 1'b0;
	logic        hreadyout, hresp;
	logic [1:0]  htrans = 2'h0;
	logic [1:0]  pre = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd;
	logic [15:0] timer_count = 16'h000c;
	logic [7:0]  port_out = 8'h00;
	logic [3:0]  fault = 4'h0;
	logic [3:0]  trip_in, pwm_true, pwm_true_oe, pwm_inv, pwm_inv_oe, gate_t, gate_n;
	logic [7:0]  tc [3] = '{8'h18, 8'h1e, 8'h20};
	logic [3:0]  te [3] = '{4'hf, 4'hc, 4'h0};
	int          n_errors = 0;
	int          compares = 0;
	int          n;
	mpg_top u_dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .timer_count, .count_tick, .port_out,
		.trip_in, .pwm_true, .pwm_true_oe, .pwm_inv, .pwm_inv_oe);
	mpg_stage u_stage (.pwm_true, .pwm_true_oe, .pwm_inv, .pwm_inv_oe, .fault, .gate_t, .gate_n,
		.trip_in);
	always #25 clk = ~clk;
	// Timer: reload 12, one tick every fourth clock, so edges are 4 clocks apart.
	always @(posedge clk) begin
		pre <= pre + 2'h1;
		count_tick <= (pre == 2'h3);
		if (pre == 2'h3) timer_count <= (timer_count == 16'h0) ? 16'h000c : timer_count - 16'h1;
	end
	task automatic end_sim;
		$display("n_errors=%0d compares=%0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Waits for the next edge that samples ready high, with a bound.
	task automatic wait_rdy;
		int g;
		g = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1 && g < 20) begin
			@(posedge clk);
			g++;
		end
		if (g >= 20) begin
			n_errors++;
			end_sim;
		end
	endtask
	// One single transfer; the address phase holds until ready, then the data phase.
	task automatic bus(input logic w, input logic [7:0] i, input logic [15:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, i, 2'h0};
		wait_rdy;
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {16'h0, d};
		wait_rdy;
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] i, input logic [15:0] d);
		bus(1'b1, i, d);
	endtask
	task automatic chk_rd(input logic [7:0] i, input logic [7:0] e);
		bus(1'b0, i, 16'h0);
		chk_val(rd, {24'h0, e});
	endtask
	task automatic skip(input logic v, inout int g);
		while (gate_t[0] === v && g < 400) begin
			@(posedge clk);
			g++;
		end
	endtask
	// Length in clocks of the next whole high phase of upper gate 0.
	task automatic hi_len(output int len);
		int g;
		g = 0;
		skip(1'b1, g);
		skip(1'b0, g);
		len = g;
		skip(1'b1, g);
		len = g - len;
		if (g >= 400) begin
			n_errors++;
			end_sim;
		end
	endtask
	// High time is four clocks per count between the edges, less the dead band of three.
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		chk_rd(mpg_pkg::IDX_ENABLE, 8'h00);
		chk_rd(mpg_pkg::IDX_GATING, 8'h00);
		chk_rd(8'h7f, 8'h00);
		wr(mpg_pkg::IDX_TRIP, 16'h00f1);
		chk_rd(mpg_pkg::IDX_TRIP, 8'hf0);
		wr(mpg_pkg::IDX_TRIP, 16'h0000);
		wr(mpg_pkg::IDX_GATING, 16'h0003);
		wr(mpg_pkg::IDX_RISE_BASE, 16'h0008);
		wr(mpg_pkg::IDX_FALL_BASE, 16'h0004);
		wr(mpg_pkg::IDX_ENABLE, 16'h0003);
		repeat (6) @(posedge clk);
		chk_pin(pwm_true_oe, 4'h1);
		chk_pin(pwm_inv_oe, 4'h0);
		wr(mpg_pkg::IDX_ENABLE, 16'h0083);
		hi_len(n);
		chk_val(32'(n), 32'h0000_000d);
		// Each edge moves by two counts only, a small part of the period.
		wr(mpg_pkg::IDX_RISE_BASE, 16'h000a);
		wr(mpg_pkg::IDX_FALL_BASE, 16'h0002);
		hi_len(n);
		chk_val(32'(n), 32'h0000_0015);
		hi_len(n);
		chk_val(32'(n), 32'h0000_001d);
		// Every gate select code for both groups; the pass codes must show the waveform.
		for (int c = 0; c < 4; c++) begin
			port_out <= (c == 2) ? 8'h11 : 8'h00;
			wr(mpg_pkg::IDX_GATING, {8'h00, c[1:0], c[1:0], 4'h3});
			if (c == 1 || c == 2) begin
				repeat (8) @(posedge clk);
				chk_pin({2'h0, gate_n[0], gate_t[0]}, (c == 2) ? 4'h3 : 4'h0);
			end else begin
				hi_len(n);
				chk_val(32'(n), 32'h0000_001d);
			end
		end
		wr(mpg_pkg::IDX_GATING, 16'h0003);
		wr(mpg_pkg::IDX_ENABLE, 16'h00c3);
		// Each trip setting: trip, drop the fault, stay tripped, then clear by software.
		for (int k = 0; k < 3; k++) begin
			wr(mpg_pkg::IDX_TRIP, {8'h00, tc[k]});
			fault <= {2'h0, tc[k][5:4]};
			repeat (8) @(posedge clk);
			chk_pin({pwm_true_oe[0], pwm_inv_oe[0], gate_t[0], gate_n[0]}, te[k]);
			chk_rd(mpg_pkg::IDX_TRIP, tc[k] | 8'h01);
			fault <= 4'h0;
			repeat (60) @(posedge clk);
			chk_pin({pwm_true_oe[0], pwm_inv_oe[0], gate_t[0], gate_n[0]}, te[k]);
			wr(mpg_pkg::IDX_TRIP, {8'h00, tc[k]});
			chk_rd(mpg_pkg::IDX_TRIP, tc[k]);
		end
		hi_len(n);
		chk_val(32'(n), 32'h0000_001d);
		// Broadcast: generator 2 gets edges that never overlap generator 0, so it can only
		// be high together with pin 0 if it really follows generator 0.
		wr(mpg_pkg::IDX_RISE_BASE + 8'h02, 16'h0001);
		wr(mpg_pkg::IDX_FALL_BASE + 8'h02, 16'h000b);
		wr(mpg_pkg::IDX_ENABLE, 16'h002b);
		hi_len(n);
		chk_val(32'(n), 32'h0000_001d);
		n = 0;
		skip(1'b0, n);
		chk_pin(gate_t, 4'h5);
		// A reset in mid-run must bring the enable register and the true pin enables back to zero.
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		chk_pin(pwm_true_oe, 4'h0);
		chk_rd(mpg_pkg::IDX_ENABLE, 8'h00);
		end_sim;
	end
endmodule
`default_nettype wire
